// *** verilog/xost_main.sv ***
// Operation
// R1: bit 7 of control stops main oscillator
// R2: stop bit acts only on internal clock
// R3: control resets to zero, bit/byte writes
// R4: software checks status bit before stop
// R5: on subsystem clock use processor stop bit
// R6: status clears on reset, stop, halts
// R7: flags set in order, stay set
// R8: flags at 2^11..2^16 cycles, upper zero
// R9: count only to selected interval
// R10: software selects interval at least polled
// R11: wait starts once oscillation begins
// R12: wait imposed only on main clock
// R13: select codes 1..5 map to intervals
// R14: select resets to 2^16, upper zero
// R15: select written by whole bytes only
// R16: program select before STOP on main
// R17: check status before rewriting select
// R18: clock status reads 0 internal, 1 main
// R19: counter increments per cycle, saturates
// R20: counter held zero while oscillator halted
`timescale 1ns/1ps
`include "xost_defs.svh"
module xost_main
  import xost_pkg::*;
#(
  parameter int CNT_W = 17
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic fxp_tick_i,
  input wire logic osc_running_i,
  input wire logic cpu_on_main_i,
  input wire logic cpu_on_sub_i,
  input wire logic proc_clock_osc_stop_bit_i,
  input wire logic stop_instr_i,
  input wire logic stop_mode_i,
  input wire logic stop_release_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic bit_wr_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic main_osc_halt_o,
  output logic stab_wait_o,
  output logic cpu_clock_status_bit_o
);
  typedef struct packed {
    logic stop_bit;
    logic [2:0] sel;
    logic [4:0] flags;
    logic waiting;
    logic [7:0] rdata;
    logic tick_s1;
    logic tick_s2;
    logic tick_s3;
    logic run_s1;
    logic run_s2;
  } xost_state_type;
  xost_state_type q_ff;
  xost_state_type nxt_q;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] limit;
  logic at_limit;
  logic clear_ev;
  logic hold;
  logic tick_pulse;
  logic wr_mosc;
  logic wr_tsel;
  logic stop_eff;
  logic [7:0] mosc_val;
  logic [4:0] flag_now;
  logic [4:0] exps [5];
  assign exps[0] = 5'(`XOST_EXP_2P16);
  assign exps[1] = 5'(`XOST_EXP_2P15);
  assign exps[2] = 5'(`XOST_EXP_2P14);
  assign exps[3] = 5'(`XOST_EXP_2P13);
  assign exps[4] = 5'(`XOST_EXP_2P11);
  // ==========================================================
  // register decode
  assign wr_mosc = wr_i && (addr_i == `XOST_ADDR_MOSC);
  // whole-byte only: a bit write here is ignored
  assign wr_tsel = wr_i && !bit_wr_i && (addr_i == `XOST_ADDR_TSEL); // [R15]
  // ==========================================================
  // stop and hold
  assign stop_eff = q_ff.stop_bit && !cpu_on_main_i && !cpu_on_sub_i; // [R2]
  assign main_osc_halt_o = stop_eff || proc_clock_osc_stop_bit_i // [R5]
                           || stop_mode_i;
  // count only once the oscillator really runs
  assign hold = main_osc_halt_o || !q_ff.run_s2; // [R11]
  assign clear_ev = stop_instr_i || stop_eff // [R6]
                    || proc_clock_osc_stop_bit_i;
  assign tick_pulse = q_ff.tick_s2 && !q_ff.tick_s3;
  // ==========================================================
  // interval limit from select code
  always_comb begin
    case (q_ff.sel)
      `XOST_SEL_2P11: limit = CNT_W'(1) << `XOST_EXP_2P11; // [R13]
      `XOST_SEL_2P13: limit = CNT_W'(1) << `XOST_EXP_2P13;
      `XOST_SEL_2P14: limit = CNT_W'(1) << `XOST_EXP_2P14;
      `XOST_SEL_2P15: limit = CNT_W'(1) << `XOST_EXP_2P15;
      default: limit = CNT_W'(1) << `XOST_EXP_2P16;
    endcase
  end
  xost_counter #(
    .CNT_W(CNT_W)
  ) u_cnt (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick_pulse),
    .clear_i(clear_ev),
    .hold_i(hold),
    .limit_i(limit),
    .count_o(count),
    .at_limit_o(at_limit)
  );
  // ==========================================================
  // thermometer flags
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_flag
      assign flag_now[gi] = count >= (CNT_W'(1) << exps[gi]); // [R8]
    end
  endgenerate
  assign mosc_val = {q_ff.stop_bit, 7'h00};
  // ==========================================================
  // next state
  always_comb begin
    nxt_q = q_ff;
    nxt_q.tick_s1 = fxp_tick_i;
    nxt_q.tick_s2 = q_ff.tick_s1;
    nxt_q.tick_s3 = q_ff.tick_s2;
    nxt_q.run_s1 = osc_running_i;
    nxt_q.run_s2 = q_ff.run_s1;
    if (wr_mosc) begin
      if (bit_wr_i) begin
        if (bit_sel_i == 3'(`XOST_STOP_BIT)) begin
          nxt_q.stop_bit = wdata_i[0]; // [R3]
        end
      end else begin
        nxt_q.stop_bit = wdata_i[`XOST_STOP_BIT]; // [R1]
      end
    end
    if (wr_tsel) begin
      nxt_q.sel = wdata_i[`XOST_SEL_MSB:0];
    end
    // flags only rise until cleared
    nxt_q.flags = q_ff.flags | flag_now; // [R7]
    if (clear_ev) begin
      nxt_q.flags = 5'h00; // [R6]
    end
    if (stop_release_i && cpu_on_main_i) begin
      nxt_q.waiting = 1'b1; // [R12]
    end else if (at_limit || !cpu_on_main_i) begin
      nxt_q.waiting = 1'b0;
    end
    case (addr_i)
      `XOST_ADDR_MOSC: nxt_q.rdata = mosc_val;
      `XOST_ADDR_STAT: nxt_q.rdata = {3'h0, q_ff.flags}; // [R8]
      `XOST_ADDR_TSEL: nxt_q.rdata = {5'h00, q_ff.sel}; // [R14]
      default: nxt_q.rdata = 8'h00;
    endcase
    if (!rd_i) begin
      nxt_q.rdata = q_ff.rdata;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      q_ff <= '0;
      q_ff.stop_bit <= 1'(`XOST_MOSC_RST >> `XOST_STOP_BIT); // [R3]
      q_ff.sel <= `XOST_TSEL_RST; // [R14]
      q_ff.flags <= 5'(`XOST_STAT_RST); // [R6]
    end else begin
      q_ff <= nxt_q;
    end
  end
  assign rdata_o = q_ff.rdata;
  assign stab_wait_o = q_ff.waiting;
  assign cpu_clock_status_bit_o = cpu_on_main_i; // [R18]
  // ==========================================================
  // checks
  sequence clr_s;
    clear_ev;
  endsequence
  flags_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    clr_s |=> q_ff.flags == 5'h00) // [R6]
    else $error("flags not cleared");
  thermo_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    q_ff.flags inside {5'h00, 5'h10, 5'h18, 5'h1c, 5'h1e, 5'h1f}) // [R7]
    else $error("flags not thermometer");
  flag_time_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (count >= 2048) && !clear_ev |=> q_ff.flags[4]) // [R8]
    else $error("first flag late");
  stop_ignored_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cpu_on_main_i && !stop_mode_i && !proc_clock_osc_stop_bit_i
    |-> !main_osc_halt_o) // [R2]
    else $error("stop bit acted off internal clock");
  stop_acts_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    q_ff.stop_bit && !cpu_on_main_i && !cpu_on_sub_i
    |-> main_osc_halt_o) // [R1]
    else $error("stop bit did not halt");
  sel_bitwr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_i && bit_wr_i |=> $stable(q_ff.sel)) // [R15]
    else $error("bit write changed select");
  sel_clamp_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    q_ff.sel == `XOST_SEL_2P11 |-> !q_ff.flags[3]) // [R9]
    else $error("flag beyond selected interval");
  wait_only_main_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    stab_wait_o |-> $past(cpu_on_main_i)) // [R12]
    else $error("wait imposed off main clock");
endmodule // xost_main

// *** common/xost_defs.svh ***
`ifndef XOST_DEFS_SVH
`define XOST_DEFS_SVH
// ==========================================================
// register addresses
`define XOST_ADDR_MOSC 16'hffa2
`define XOST_ADDR_STAT 16'hffa3
`define XOST_ADDR_TSEL 16'hffa4
// ==========================================================
// field positions
`define XOST_STOP_BIT 7
`define XOST_SEL_MSB 2
// ==========================================================
// reset values
`define XOST_MOSC_RST 8'h00
`define XOST_STAT_RST 8'h00
`define XOST_TSEL_RST 3'h5
// ==========================================================
// select codes and interval exponents
`define XOST_SEL_2P11 3'h1
`define XOST_SEL_2P13 3'h2
`define XOST_SEL_2P14 3'h3
`define XOST_SEL_2P15 3'h4
`define XOST_SEL_2P16 3'h5
`define XOST_EXP_2P11 11
`define XOST_EXP_2P13 13
`define XOST_EXP_2P14 14
`define XOST_EXP_2P15 15
`define XOST_EXP_2P16 16
`endif

// *** common/xost_pkg.sv ***
package xost_pkg;
  typedef enum logic [1:0] {
    XOST_CLK_INTOSC,
    XOST_CLK_MAIN,
    XOST_CLK_SUB
  } xost_cpuclk_type;
  typedef enum logic [1:0] {
    XOST_ST_HELD,
    XOST_ST_COUNT,
    XOST_ST_DONE
  } xost_cnt_state_type;
endpackage

// *** verilog/xost_counter.sv ***
`timescale 1ns/1ps
`include "xost_defs.svh"
// stabilization counter, ticks on main oscillator enable pulses
module xost_counter
  import xost_pkg::*;
#(
  parameter int CNT_W = 17
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic clear_i,
  input wire logic hold_i,
  input wire logic [CNT_W-1:0] limit_i,
  output logic [CNT_W-1:0] count_o,
  output logic at_limit_o
);
  typedef struct packed {
    xost_cnt_state_type st;
    logic [CNT_W-1:0] cnt;
  } xost_cnt_type;
  xost_cnt_type q_ff;
  xost_cnt_type nxt_q;
  // ==========================================================
  // next state
  always_comb begin
    nxt_q = q_ff;
    case (q_ff.st)
      XOST_ST_HELD: begin
        nxt_q.cnt = '0;
        if (!hold_i) begin
          nxt_q.st = XOST_ST_COUNT;
          // a tick on the release cycle must not be lost
          if (tick_i) begin
            nxt_q.cnt = CNT_W'(1); // [R11]
          end
        end
      end
      XOST_ST_COUNT: begin
        // saturate: no wrap avoids flags falling back to zero
        if (tick_i) begin
          nxt_q.cnt = q_ff.cnt + 1'b1; // [R19]
        end
        if (nxt_q.cnt >= limit_i) begin
          nxt_q.st = XOST_ST_DONE; // [R9]
        end
      end
      XOST_ST_DONE: begin
        if (limit_i > q_ff.cnt) begin
          nxt_q.st = XOST_ST_COUNT;
        end
      end
      default: begin
        nxt_q.st = XOST_ST_HELD;
      end
    endcase
    if (clear_i || hold_i) begin
      nxt_q.cnt = '0; // [R20]
      nxt_q.st = XOST_ST_HELD;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      q_ff <= '{st: XOST_ST_HELD, cnt: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end
  assign count_o = q_ff.cnt;
  assign at_limit_o = (q_ff.st == XOST_ST_DONE);
  // ==========================================================
  // checks
  never_past_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    q_ff.cnt <= limit_i || $past(limit_i) != limit_i) // [R9]
    else $error("counter ran past its limit");
  held_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $past(hold_i) |-> q_ff.cnt == '0) // [R20]
    else $error("counter moved while oscillator halted");
endmodule // xost_counter

// *** verif/xost_main_bench.sv ***
`timescale 1ns/1ps
`include "xost_defs.svh"
module xost_main_bench;
  import xost_pkg::*;
  logic mclk_i = 0, rst_n_i = 0, fxp_tick_i = 0, osc_running_i = 1;
  logic cpu_on_main_i = 0, cpu_on_sub_i = 0, proc_clock_osc_stop_bit_i = 0;
  logic stop_instr_i = 0, stop_mode_i = 0, stop_release_i = 0;
  logic [15:0] addr_i = 16'h0000;
  logic wr_i = 0, bit_wr_i = 0, rd_i = 0;
  logic [2:0] bit_sel_i = 3'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o, r, d;
  logic main_osc_halt_o, stab_wait_o, cpu_clock_status_bit_o;
  int error_cnt = 0, cmp_count = 0, i;
  // ==========================================================
  // clock and design
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  xost_main DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .fxp_tick_i(fxp_tick_i), .osc_running_i(osc_running_i),
    .cpu_on_main_i(cpu_on_main_i), .cpu_on_sub_i(cpu_on_sub_i),
    .proc_clock_osc_stop_bit_i(proc_clock_osc_stop_bit_i),
    .stop_instr_i(stop_instr_i), .stop_mode_i(stop_mode_i),
    .stop_release_i(stop_release_i), .addr_i(addr_i), .wr_i(wr_i),
    .bit_wr_i(bit_wr_i), .bit_sel_i(bit_sel_i), .wdata_i(wdata_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .main_osc_halt_o(main_osc_halt_o),
    .stab_wait_o(stab_wait_o),
    .cpu_clock_status_bit_o(cpu_clock_status_bit_o));
  // ==========================================================
  // compares and expectations
  task automatic chk8(string n, logic [7:0] e, logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk1(string n, logic e, logic s);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", n, e, s);
    end
  endtask
  // effective stop bit only counts while the cpu runs on the internal clock
  function automatic logic halt_exp(logic stp);
    halt_exp = (stp & !cpu_on_main_i & !cpu_on_sub_i) |
      proc_clock_osc_stop_bit_i | stop_mode_i;
  endfunction
  // ==========================================================
  // bus and oscillator drivers, entered just after a rising edge
  task automatic wr(logic [15:0] a, logic [7:0] v, logic b, logic [2:0] s);
    addr_i = a;
    wdata_i = v;
    bit_wr_i = b;
    bit_sel_i = s;
    wr_i = 1;
    @(posedge mclk_i);
    #1 wr_i = 0;
    bit_wr_i = 0;
    // let an edge pass so back-to-back writes never re-raise in one step
    @(posedge mclk_i);
    #1;
  endtask
  task automatic rd(logic [15:0] a);
    addr_i = a;
    rd_i = 1;
    @(posedge mclk_i);
    #1 rd_i = 0;
    @(posedge mclk_i);
    #1 r = rdata_o;
  endtask
  // each tick spans two cycles so the synchronizer sees every edge
  task automatic tick(int n);
    repeat (n) begin
      fxp_tick_i = 1;
      @(posedge mclk_i);
      #1 fxp_tick_i = 0;
      @(posedge mclk_i);
      #1;
    end
    repeat (6) @(posedge mclk_i);
    #1;
  endtask
  task automatic pulse(ref logic p);
    p = 1;
    @(posedge mclk_i);
    #1 p = 0;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(13));
    repeat (6) @(posedge mclk_i);
    #1 rst_n_i = 1;
    rd(`XOST_ADDR_MOSC);
    chk8("control", `XOST_MOSC_RST, r);
    rd(`XOST_ADDR_STAT);
    chk8("status", `XOST_STAT_RST, r);
    rd(`XOST_ADDR_TSEL);
    chk8("select", {5'h00, `XOST_TSEL_RST}, r);
    rd(16'hffa5);
    chk8("unmapped", 8'h00, r);
    chk1("clock status", 1'b0, cpu_clock_status_bit_o);
    $display("test reset values done");
    tick(2047);
    rd(`XOST_ADDR_STAT);
    chk8("status", 8'h00, r);
    tick(1);
    rd(`XOST_ADDR_STAT);
    chk8("status", 8'h10, r);
    tick(6143);
    rd(`XOST_ADDR_STAT);
    chk8("status", 8'h10, r);
    tick(1);
    rd(`XOST_ADDR_STAT);
    chk8("status", 8'h18, r);
    $display("test flag thresholds done");
    chk1("clock status", 1'b0, cpu_clock_status_bit_o);
    wr(`XOST_ADDR_MOSC, 8'hff, 1'b0, 3'h0);
    rd(`XOST_ADDR_MOSC);
    chk8("control", 8'h80, r);
    chk1("halt", 1'b1, main_osc_halt_o);
    rd(`XOST_ADDR_STAT);
    chk8("status", 8'h00, r);
    wr(`XOST_ADDR_MOSC, 8'h00, 1'b1, 3'h7);
    wr(`XOST_ADDR_MOSC, 8'h01, 1'b1, 3'h6);
    rd(`XOST_ADDR_MOSC);
    chk8("control", 8'h00, r);
    for (i = 0; i < 8; i++) begin
      d = 8'($urandom);
      cpu_on_main_i = 1'($urandom);
      cpu_on_sub_i = !cpu_on_main_i && 1'($urandom);
      wr(`XOST_ADDR_MOSC, d, 1'b0, 3'h0);
      rd(`XOST_ADDR_MOSC);
      chk8("control", {d[7], 7'h00}, r);
      chk1("halt", halt_exp(d[7]), main_osc_halt_o);
      chk1("clock status", cpu_on_main_i, cpu_clock_status_bit_o);
    end
    cpu_on_main_i = 0;
    cpu_on_sub_i = 1;
    wr(`XOST_ADDR_MOSC, 8'h00, 1'b0, 3'h0);
    proc_clock_osc_stop_bit_i = 1;
    tick(2100);
    chk1("halt", 1'b1, main_osc_halt_o);
    rd(`XOST_ADDR_STAT);
    chk8("status", 8'h00, r);
    proc_clock_osc_stop_bit_i = 0;
    cpu_on_sub_i = 0;
    $display("test control register done");
    wr(`XOST_ADDR_TSEL, 8'hfa, 1'b0, 3'h0);
    wr(`XOST_ADDR_TSEL, 8'h01, 1'b1, 3'h2);
    rd(`XOST_ADDR_TSEL);
    chk8("select", 8'h02, r);
    rd(`XOST_ADDR_STAT);
    chk8("status", 8'h00, r);
    // shortest wait, and only the shortest flag is polled later
    wr(`XOST_ADDR_TSEL, {5'h00, `XOST_SEL_2P11}, 1'b0, 3'h0);
    tick(100);
    pulse(stop_instr_i);
    stop_mode_i = 1;
    rd(`XOST_ADDR_STAT);
    chk8("status", 8'h00, r);
    chk1("halt", 1'b1, main_osc_halt_o);
    cpu_on_main_i = 1;
    osc_running_i = 0;
    stop_mode_i = 0;
    pulse(stop_release_i);
    chk1("wait", 1'b1, stab_wait_o);
    tick(50);
    osc_running_i = 1;
    tick(2047);
    chk1("wait", 1'b1, stab_wait_o);
    tick(1);
    chk1("wait", 1'b0, stab_wait_o);
    tick(6200);
    rd(`XOST_ADDR_STAT);
    chk8("status", 8'h10, r);
    cpu_on_main_i = 0;
    pulse(stop_release_i);
    chk1("wait", 1'b0, stab_wait_o);
    $display("test stop release done");
    summarize();
  end
endmodule // xost_main_bench
